//--- logic/par_pkg.sv
package par_pkg;
    // Register offsets (byte addresses on the register port)
    localparam logic [7:0] PAR_ADDR_CH1_SEL = 8'h07;
    localparam logic [7:0] PAR_ADDR_CH2_SEL = 8'h08;
    localparam logic [7:0] PAR_ADDR_CH3_SEL = 8'h09;
    localparam logic [7:0] PAR_ADDR_RECOV = 8'h0a;
    localparam logic [7:0] PAR_ADDR_GAIN = 8'h0b;
    localparam logic [7:0] PAR_ADDR_MISC = 8'h0c;
    localparam logic [7:0] PAR_ADDR_CTRL = 8'h20;
    localparam logic [7:0] PAR_ADDR_STATUS = 8'h21;

    // Reset values
    localparam logic [7:0] PAR_RST_CH1_SEL = 8'h03;
    localparam logic [7:0] PAR_RST_CH2_SEL = 8'h03;
    localparam logic [7:0] PAR_RST_CH3_SEL = 8'h03;
    localparam logic [7:0] PAR_RST_RECOV = 8'h70;
    localparam logic [7:0] PAR_RST_GAIN = 8'h00;
    localparam logic [7:0] PAR_RST_MISC = 8'h04;

    // Field positions
    localparam int PAR_REC_LSB = 4;
    localparam int PAR_REC_MSB = 6;
    localparam int PAR_MODE_BIT = 2;
    localparam int PAR_GAIN_MSB = 2;
    localparam int PAR_CTRL_START = 0;
    localparam int PAR_CTRL_CH_LSB = 1;

    // Writable bits of each register
    localparam logic [7:0] PAR_MASK_RECOV = 8'h70;
    localparam logic [7:0] PAR_MASK_GAIN = 8'h07;
    localparam logic [7:0] PAR_MASK_MISC = 8'h24;

    // Input select codes
    localparam logic [7:0] PAR_SEL_SMALL_IR = 8'h00;
    localparam logic [7:0] PAR_SEL_VISIBLE = 8'h02;
    localparam logic [7:0] PAR_SEL_LARGE_IR = 8'h03;
    localparam logic [7:0] PAR_SEL_NO_PD = 8'h06;
    localparam logic [7:0] PAR_SEL_GND = 8'h25;
    localparam logic [7:0] PAR_SEL_TEMP = 8'h65;
    localparam logic [7:0] PAR_SEL_VDD = 8'h75;

    // Timing: one recovery ADC clock at unity gain
    localparam int PAR_ADC_CLK_NS = 50;
    localparam int PAR_SYS_CLK_NS = 20;
    localparam int PAR_ADC_CLK_CYC = (PAR_ADC_CLK_NS + PAR_SYS_CLK_NS - 1)
        / PAR_SYS_CLK_NS;

    typedef enum logic [2:0] {
        PAR_ST_IDLE = 3'b001,
        PAR_ST_RECOVER = 3'b010,
        PAR_ST_CONVERT = 3'b100
    } par_state_t;
endpackage

//--- logic/par_clk_div.sv
module par_clk_div
    import par_pkg::*;
#(
    parameter int DIV = PAR_ADC_CLK_CYC
)(
    input wire logic clk_sys_i, // System clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic clr_i, // Restart the divider
    output logic tick_o // One-cycle ADC clock enable
);
    logic [7:0] cnt_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= 8'h00;
            tick_o <= 1'b0;
        end
        else if (clr_i || cnt_q == 8'(DIV - 1))
        begin
            cnt_q <= 8'h00;
            tick_o <= !clr_i;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
            tick_o <= 1'b0;
        end
    end
endmodule

//--- logic/par_cfg_regs.sv
module par_cfg_regs
    import par_pkg::*;
#(
    parameter logic [7:0] RST = 8'h00,
    parameter logic [7:0] MASK = 8'hff
)(
    input wire logic clk_sys_i, // System clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic we_i, // Write strobe for this register
    input wire logic [7:0] wdata_i, // Write data
    output logic [7:0] q_o // Stored value
);
    // Reserved bits stay zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q_o <= RST;
        else if (we_i)
            q_o <= wdata_i & MASK;
    end
endmodule

//--- logic/par_top.sv
module par_top
    import par_pkg::*;
(
    input wire logic clk_sys_i, // System clock, 50 MHz
    input wire logic rst_n_i, // Async reset, active low
    input wire logic [7:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Register write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, cycle after strobe
    input wire logic conv_done_i, // Converter finished integration
    output logic [7:0] adc_sel_o, // Source routed to the converter
    output logic [2:0] led_en_o, // LED drive allowed per channel
    output logic raw_mode_o, // Raw converter measurement active
    output logic recover_o, // Recovery wait in progress
    output logic convert_o, // Conversion in progress
    output logic [3:0] integ_scale_o // Log2 of integration lengthening
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] sel_q [3];
    logic [7:0] recov_q;
    logic [7:0] gain_q;
    logic [7:0] misc_q;
    logic [2:0] we_sel;
    logic we_recov;
    logic we_gain;
    logic we_misc;
    logic start_req;
    logic [1:0] start_ch;

    assign we_sel[0] = wr_i && addr_i == PAR_ADDR_CH1_SEL;
    assign we_sel[1] = wr_i && addr_i == PAR_ADDR_CH2_SEL;
    assign we_sel[2] = wr_i && addr_i == PAR_ADDR_CH3_SEL;
    assign we_recov = wr_i && addr_i == PAR_ADDR_RECOV;
    assign we_gain = wr_i && addr_i == PAR_ADDR_GAIN;
    assign we_misc = wr_i && addr_i == PAR_ADDR_MISC;
    assign start_req = wr_i && addr_i == PAR_ADDR_CTRL
        && wdata_i[PAR_CTRL_START];
    assign start_ch = wdata_i[PAR_CTRL_CH_LSB +: 2];

    par_cfg_regs #(.RST(PAR_RST_CH1_SEL), .MASK(8'hff)) u_sel1 (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .we_i(we_sel[0]),
        .wdata_i(wdata_i),
        .q_o(sel_q[0])
    );
    par_cfg_regs #(.RST(PAR_RST_CH2_SEL), .MASK(8'hff)) u_sel2 (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .we_i(we_sel[1]),
        .wdata_i(wdata_i),
        .q_o(sel_q[1])
    );
    par_cfg_regs #(.RST(PAR_RST_CH3_SEL), .MASK(8'hff)) u_sel3 (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .we_i(we_sel[2]),
        .wdata_i(wdata_i),
        .q_o(sel_q[2])
    );
    par_cfg_regs #(.RST(PAR_RST_RECOV), .MASK(PAR_MASK_RECOV)) u_rec (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .we_i(we_recov),
        .wdata_i(wdata_i),
        .q_o(recov_q)
    );
    par_cfg_regs #(.RST(PAR_RST_GAIN), .MASK(PAR_MASK_GAIN)) u_gain (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .we_i(we_gain),
        .wdata_i(wdata_i),
        .q_o(gain_q)
    );
    par_cfg_regs #(.RST(PAR_RST_MISC), .MASK(PAR_MASK_MISC)) u_misc (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .we_i(we_misc),
        .wdata_i(wdata_i),
        .q_o(misc_q)
    );

    // ------------------------------------------------------------
    // Decode of the active configuration
    // ------------------------------------------------------------
    logic prox_mode;
    logic [2:0] rec_code;
    logic [2:0] gain;
    logic [7:0] cur_sel;
    logic sel_valid;

    assign prox_mode = misc_q[PAR_MODE_BIT];
    assign rec_code = recov_q[PAR_REC_MSB:PAR_REC_LSB];
    assign gain = gain_q[PAR_GAIN_MSB:0];

    // Checks a select code against the set allowed by the mode
    function automatic logic code_ok(input logic [7:0] c, input logic pm);
        logic ir;
        ir = c == PAR_SEL_LARGE_IR || c == PAR_SEL_SMALL_IR;
        if (pm)
            code_ok = ir;
        else
            code_ok = ir || c == PAR_SEL_VISIBLE
                || c == PAR_SEL_NO_PD
                || c == PAR_SEL_GND
                || c == PAR_SEL_TEMP
                || c == PAR_SEL_VDD;
    endfunction

    // ------------------------------------------------------------
    // Recovery and conversion sequencer
    // ------------------------------------------------------------
    par_state_t state_q;
    logic [1:0] ch_q;
    logic [8:0] rec_left_q;
    logic [7:0] scale_left_q;
    logic adc_tick;
    logic tick_clr;
    logic bad_code_q;

    assign cur_sel = sel_q[ch_q];
    assign sel_valid = code_ok(sel_q[start_ch], prox_mode);
    assign tick_clr = state_q != PAR_ST_RECOVER;

    par_clk_div u_div (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clr_i(tick_clr),
        .tick_o(adc_tick)
    );

    // Clocks to wait: code 0 gives 1, code n gives 2^(n+2)-1
    function automatic logic [8:0] rec_clocks(input logic [2:0] code);
        if (code == 3'h0)
            rec_clocks = 9'h001;
        else
            rec_clocks = 9'((10'h1 << ({1'b0, code} + 4'h2)) - 10'h1);
    endfunction

    logic go;
    logic rec_end;
    logic [7:0] scale_init;

    assign go = state_q == PAR_ST_IDLE && start_req && start_ch != 2'h3;
    assign rec_end = adc_tick && scale_left_q == 8'h00
        && rec_left_q == 9'h001;
    assign scale_init = 8'((9'h1 << gain) - 9'h1);

    // Sequencer state
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_q <= PAR_ST_IDLE;
        else
        begin
            case (state_q)
                PAR_ST_IDLE:
                begin
                    if (go)
                        state_q <= PAR_ST_RECOVER;
                end
                PAR_ST_RECOVER:
                begin
                    if (rec_end)
                        state_q <= PAR_ST_CONVERT;
                end
                PAR_ST_CONVERT:
                begin
                    if (conv_done_i)
                        state_q <= PAR_ST_IDLE;
                end
                default:
                    state_q <= PAR_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Channel capture and recovery counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ch_q <= 2'h0;
            bad_code_q <= 1'b0;
        end
        else if (go)
        begin
            ch_q <= start_ch;
            bad_code_q <= !sel_valid;
        end
    end

    // Gain prescaler inside, ADC clock count outside
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rec_left_q <= 9'h000;
            scale_left_q <= 8'h00;
        end
        else if (go)
        begin
            rec_left_q <= rec_clocks(rec_code);
            scale_left_q <= scale_init;
        end
        else if (state_q == PAR_ST_RECOVER && adc_tick)
        begin
            if (scale_left_q != 8'h00)
                scale_left_q <= scale_left_q - 8'h01;
            else if (rec_left_q != 9'h001)
            begin
                rec_left_q <= rec_left_q - 9'h001;
                scale_left_q <= scale_init;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs to the analog front end
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            adc_sel_o <= PAR_SEL_LARGE_IR;
            raw_mode_o <= 1'b0;
            recover_o <= 1'b0;
            convert_o <= 1'b0;
            integ_scale_o <= 4'h0;
        end
        else
        begin
            adc_sel_o <= cur_sel;
            raw_mode_o <= !prox_mode;
            recover_o <= state_q == PAR_ST_RECOVER;
            convert_o <= state_q == PAR_ST_CONVERT;
            integ_scale_o <= {1'b0, gain};
        end
    end

    // LED drive only while converting in proximity mode
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            led_en_o <= 3'h0;
        else
        begin
            led_en_o <= 3'h0;
            if (prox_mode && state_q == PAR_ST_CONVERT)
                led_en_o[ch_q] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= 8'h00;
        else if (rd_i)
        begin
            if (addr_i == PAR_ADDR_CH1_SEL)
                rdata_o <= sel_q[0];
            else if (addr_i == PAR_ADDR_CH2_SEL)
                rdata_o <= sel_q[1];
            else if (addr_i == PAR_ADDR_CH3_SEL)
                rdata_o <= sel_q[2];
            else if (addr_i == PAR_ADDR_RECOV)
                rdata_o <= recov_q;
            else if (addr_i == PAR_ADDR_GAIN)
                rdata_o <= gain_q;
            else if (addr_i == PAR_ADDR_MISC)
                rdata_o <= misc_q;
            else if (addr_i == PAR_ADDR_STATUS)
                rdata_o <= {2'h0, bad_code_q, ch_q, state_q};
            else
                rdata_o <= 8'h00;
        end
        else
            rdata_o <= 8'h00;
    end
endmodule

//--- sim/par_top_sva.sv
module par_top_sva
    import par_pkg::*;
(
    input wire logic clk_sys_i, // Clock
    input wire logic rst_n_i, // Reset
    input wire logic [7:0] addr_i, // Address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    input wire logic [7:0] rdata_o, // Read data
    input wire logic conv_done_i, // Converter done
    input wire logic [7:0] adc_sel_o, // Source select
    input wire logic [2:0] led_en_o, // LED enables
    input wire logic raw_mode_o, // Raw mode
    input wire logic recover_o, // Recovery wait
    input wire logic convert_o, // Conversion
    input wire logic [3:0] integ_scale_o // Gain scale
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");

    property p_wr_rd;
        wr_i && addr_i == PAR_ADDR_CH2_SEL ##1 !wr_i
            ##1 rd_i && addr_i == PAR_ADDR_CH2_SEL
            |=> rdata_o == $past(wdata_i, 3);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("select readback");

    property p_raw_led;
        raw_mode_o |-> led_en_o == 3'b000;
    endproperty
    a_raw_led: assert property (p_raw_led)
        else $error("LED in raw mode");

    property p_led_conv;
        led_en_o != 3'b000 |-> convert_o && $onehot(led_en_o);
    endproperty
    a_led_conv: assert property (p_led_conv)
        else $error("LED outside conv");

    property p_start;
        wr_i && addr_i == PAR_ADDR_CTRL && wdata_i[0] && wdata_i[2:1] != 2'h3
            && !recover_o && !convert_o
            && !$past(wr_i && addr_i == PAR_ADDR_CTRL && wdata_i[0])
            |-> ##2 recover_o;
    endproperty
    a_start: assert property (p_start) else $error("no recovery wait");

    property p_conv_after;
        $rose(convert_o) |-> $past(recover_o);
    endproperty
    a_conv_after: assert property (p_conv_after)
        else $error("no recovery");

    property p_done;
        convert_o && conv_done_i |-> ##[1:2] !convert_o;
    endproperty
    a_done: assert property (p_done) else $error("convert stuck");

    property p_integ;
        $changed(integ_scale_o) |-> $past(wr_i && addr_i == PAR_ADDR_GAIN)
            || $past(wr_i && addr_i == PAR_ADDR_GAIN, 2);
    endproperty
    a_integ: assert property (p_integ) else $error("scale w/o write");
endmodule

bind par_top par_top_sva u_sva (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .conv_done_i(conv_done_i), .adc_sel_o(adc_sel_o), .led_en_o(led_en_o),
    .raw_mode_o(raw_mode_o), .recover_o(recover_o), .convert_o(convert_o),
    .integ_scale_o(integ_scale_o)
);

//--- sim/par_conv_model.sv
module par_conv_model (
    input wire logic clk_sys_i, // Clock
    input wire logic rst_n_i, // Reset
    input wire logic convert_i, // Conversion running
    input wire logic [7:0] delay_i, // Integration cycles
    output logic done_o // One-cycle done pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    logic armed_q;

    // One done pulse per conversion, after a chosen delay
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= 8'h00;
            armed_q <= 1'b1;
            done_o <= 1'b0;
        end
        else if (!convert_i)
        begin
            cnt_q <= 8'h00;
            armed_q <= 1'b1;
            done_o <= 1'b0;
        end
        else if (armed_q && cnt_q == delay_i)
        begin
            armed_q <= 1'b0;
            done_o <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
            done_o <= 1'b0;
        end
    end
endmodule

//--- sim/par_top_tb.sv
module par_top_tb
    import par_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0;
    logic rst_n_i, wr_i, rd_i, conv_done_i, raw_mode_o, recover_o, convert_o;
    logic [7:0] addr_i, wdata_i, rdata_o, adc_sel_o, dly;
    logic [2:0] led_en_o;
    logic [3:0] integ_scale_o;
    int n_errors, checks, cyc, rec_cnt;
    logic [7:0] ad [7] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h30};
    logic [7:0] rv [7] = '{8'h03, 8'h03, 8'h03, 8'h70, 8'h00, 8'h04, 8'h00};
    logic [7:0] mk [7] = '{8'hff, 8'hff, 8'hff, 8'h70, 8'h07, 8'h24, 8'h00};
    logic [7:0] cd [7] = '{PAR_SEL_LARGE_IR, PAR_SEL_SMALL_IR, PAR_SEL_VISIBLE,
        PAR_SEL_NO_PD, PAR_SEL_GND, PAR_SEL_TEMP, PAR_SEL_VDD};

    par_top uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .conv_done_i(conv_done_i), .adc_sel_o(adc_sel_o),
        .led_en_o(led_en_o), .raw_mode_o(raw_mode_o),
        .recover_o(recover_o), .convert_o(convert_o),
        .integ_scale_o(integ_scale_o));
    par_conv_model u_conv (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .convert_i(convert_o), .delay_i(dly), .done_o(conv_done_i));

    always #10 clk_sys_i = ~clk_sys_i;

    task automatic finish_test();
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog and recovery length counter
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (recover_o === 1'b1)
            rec_cnt++;
        if (cyc == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    function automatic int rec_exp(input int r, input int g);
        return (r == 0 ? 1 : (1 << (r + 2)) - 1) * (1 << g) * PAR_ADC_CLK_CYC;
    endfunction

    initial
    begin
        logic [7:0] v, c;
        int ch, e;
        logic m;
        {rst_n_i, wr_i, rd_i} = 3'b000;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        dly = 8'h00;
        v = $urandom(58);
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rd(ad[i], v);
            chk(v, rv[i]);
        end
        for (int i = 0; i < 7; i++)
        begin
            c = 8'($urandom);
            wr(ad[i], c);
            rd(ad[i], v);
            chk(v, c & mk[i]);
        end
        for (int i = 0; i < 21; i++)
        begin
            wr(ad[i % 3], cd[i / 3]);
            rd(ad[i % 3], v);
            chk(v, cd[i / 3]);
        end
        for (int g = 0; g < 8; g++)
        begin
            ch = g % 3;
            m = g[0];
            c = m ? cd[$urandom % 2] : cd[$urandom % 7];
            dly = 8'($urandom % 16);
            wr(PAR_ADDR_MISC, {5'h00, m, 2'b00});
            wr(PAR_ADDR_GAIN, 8'(g));
            wr(PAR_ADDR_RECOV, {1'b0, ~3'(g), 4'h0});
            wr(ad[ch], c);
            rec_cnt = 0;
            wr(PAR_ADDR_CTRL, {5'h00, 2'(ch), 1'b1});
            while (recover_o !== 1'b1) @(posedge clk_sys_i) #1;
            wr(PAR_ADDR_CTRL, {5'h00, 2'((ch + 1) % 3), 1'b1});
            while (convert_o !== 1'b1) @(posedge clk_sys_i) #1;
            chk(adc_sel_o, c);
            chk({5'h00, led_en_o}, m ? 8'(1 << ch) : 8'h00);
            chk({7'h00, raw_mode_o}, {7'h00, ~m});
            chk({4'h0, integ_scale_o}, 8'(g));
            while (convert_o === 1'b1) @(posedge clk_sys_i) #1;
            e = rec_exp(7 - g, g);
            chk({7'h00, rec_cnt > e - 6 && rec_cnt < e + 6}, 8'h01);
        end
        // Raw visible and reference reads, a bad code, an ignored channel
        wr(PAR_ADDR_RECOV, 8'h00);
        wr(PAR_ADDR_GAIN, 8'h00);
        wr(PAR_ADDR_CH1_SEL, PAR_SEL_VISIBLE);
        wr(PAR_ADDR_CH2_SEL, PAR_SEL_NO_PD);
        wr(PAR_ADDR_CH3_SEL, PAR_SEL_GND);
        for (int i = 0; i < 4; i++)
        begin
            wr(PAR_ADDR_MISC, i > 1 ? 8'h04 : 8'h00);
            wr(PAR_ADDR_CTRL, {5'h00, 2'(i), 1'b1});
            if (i < 3)
            begin
                while (convert_o !== 1'b1) @(posedge clk_sys_i) #1;
                chk(adc_sel_o, cd[i + 2]);
                while (convert_o === 1'b1) @(posedge clk_sys_i) #1;
            end
            rd(PAR_ADDR_STATUS, v);
            chk(v, {2'h0, i > 1, i > 2 ? 2'h2 : 2'(i), 3'b001});
        end
        finish_test();
    end
endmodule
